//--- core/gpio_regs_pkg.sv
// Register map, field positions and reset values of the monitor pin block
package gpio_regs_pkg;

   // Register indices; the byte address on the bus is four times the index
   localparam logic [7:0] IDX_FUNC_SELECT   = 8'h47;
   localparam logic [7:0] IDX_DIRECTION     = 8'h49;
   localparam logic [7:0] IDX_OUT_ONLY_DATA = 8'h4a;
   localparam logic [7:0] IDX_LINE_DATA     = 8'h4b;
   localparam logic [7:0] IDX_VENDOR_LO     = 8'h4c;
   localparam logic [7:0] IDX_VENDOR_HI     = 8'h4d;
   localparam logic [7:0] IDX_CHIP_CODE     = 8'h4e;
   localparam logic [7:0] IDX_RESERVED_A    = 8'h4f;
   localparam logic [7:0] IDX_RESERVED_B    = 8'h50;
   localparam logic [7:0] IDX_DRIVE_TYPE    = 8'h51;

   localparam int IDX_W    = 8;
   localparam int ADDR_LSB = 2;
   localparam int DATA_W   = 8;
   localparam int BUS_W    = 32;

   // Bit positions in direction, data and drive-type registers
   localparam int BIT_LINE_E = 0;
   localparam int BIT_LINE_F = 1;
   localparam int BIT_LINE_G = 4;
   localparam int BIT_LINE_A = 5;
   localparam int BIT_LINE_B = 6;

   // Bit positions in the output-only data register
   localparam int BIT_OUT_C = 5;
   localparam int BIT_OUT_D = 6;
   localparam int STRAP_W   = 5;

   // Bit positions in the function-select register
   localparam int FSEL_OUT_CD = 0;
   localparam int FSEL_LINE_E = 1;
   localparam int FSEL_LINE_F = 2;
   localparam int FSEL_LINE_G = 5;
   localparam int FSEL_LINE_A = 6;
   localparam int FSEL_LINE_B = 7;

   // Writable bits of each register
   localparam logic [7:0] MASK_LINES     = 8'h73;
   localparam logic [7:0] MASK_FUNC_SEL  = 8'he7;
   localparam logic [7:0] MASK_OUT_ONLY  = 8'h7f;

   // Reset values
   localparam logic [7:0] RST_FUNC_SELECT = 8'h00;
   localparam logic [7:0] RST_DIRECTION   = 8'h00;
   localparam logic [7:0] RST_LINE_DATA   = 8'h00;
   localparam logic [7:0] RST_DRIVE_TYPE  = 8'h00;
   localparam logic [2:0] RST_OUT_TOP     = 3'h0;
   localparam logic [7:0] RST_READDATA    = 8'h00;

   localparam logic [23:0] READ_PAD = 24'h000000;

   // Avalon-MM response codes
   localparam logic [1:0] RESP_OKAY      = 2'h0;
   localparam logic [1:0] RESP_DECODEERR = 2'h3;

   typedef enum logic {
      BUS_IDLE,
      BUS_ACK
   } bus_state_t;

endpackage : gpio_regs_pkg

//--- core/io_line_ctrl.sv
// One shared bidirectional pin: function select, direction, drive type, input synchroniser
`timescale 1ns/10ps
module io_line_ctrl (
   input  wire logic sys_clk_in,
   input  wire logic reset_in,
   input  wire logic gpio_sel_in,
   input  wire logic dir_out_in,
   input  wire logic push_pull_in,
   input  wire logic value_in,
   input  wire logic alt_out_in,
   input  wire logic alt_oe_in,
   input  wire logic pin_in,
   output logic      pin_out,
   output logic      pin_oe_out,
   output logic      level_out
);

   logic sync1_r;
   logic sync2_r;
   logic out_nxt;
   logic oe_nxt;

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
      end else begin
         sync1_r <= pin_in;
         sync2_r <= sync1_r;
      end
   end

   assign level_out = sync2_r;

   always_comb begin
      if (!gpio_sel_in) begin
         // Alternate function owns the pin
         out_nxt = alt_out_in;
         oe_nxt  = alt_oe_in;
      end else if (!dir_out_in) begin
         out_nxt = 1'b0;
         oe_nxt  = 1'b0;
      end else if (push_pull_in) begin
         out_nxt = value_in;
         oe_nxt  = 1'b1;
      end else begin
         // Open drain: pull low, release for high
         out_nxt = 1'b0;
         oe_nxt  = ~value_in;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         pin_out    <= 1'b0;
         pin_oe_out <= 1'b0;
      end else begin
         pin_out    <= out_nxt;
         pin_oe_out <= oe_nxt;
      end
   end

endmodule : io_line_ctrl

//--- core/monitor_gpio_and_id_regs.sv
// General-purpose pin registers and identification bytes behind an Avalon-MM slave
`timescale 1ns/10ps

//
// Contract
// - direction bit 6 sets io_line_b input/output
// - direction bit 5 sets io_line_a input/output
// - direction bit 4 sets io_line_g input/output
// - direction bit 1 sets io_line_f input/output
// - direction bit 0 sets io_line_e input/output
// - direction acts only in general-purpose function
// - out_line_d follows output-only data bit 6
// - out_line_c follows output-only data bit 5
// - output-only reset: top bits zero, low straps
// - data bit 6 drives io_line_b, reads pin
// - data bit 5 drives io_line_a, reads pin
// - data bit 4 drives io_line_g, reads pin
// - data bit 1 drives io_line_f, reads pin
// - data bit 0 drives io_line_e, reads pin
// - vendor code low byte, then high byte
// - chip code register fixed and read-only
// - drive bit 6 io_line_b push-pull else open-drain
// - drive bit 5 io_line_a push-pull else open-drain
// - drive bit 4 io_line_g push-pull else open-drain
// - drive bit 1 io_line_f push-pull else open-drain
// - drive bit 0 io_line_e push-pull else open-drain
// - function select picks alternate or general-purpose line
// - function select bit 0 enables out_line_c/d
module monitor_gpio_and_id_regs
   import gpio_regs_pkg::*;
#(
   parameter int             ADDR_W      = 10,
   parameter logic [15:0]    VENDOR_CODE = 16'h1234, // Value is arbitrary
   parameter logic [7:0]     PART_CODE   = 8'h42     // Value is arbitrary
) (
   input  wire logic              sys_clk_in,
   input  wire logic              reset_in,
   // Avalon-MM slave
   input  wire logic [ADDR_W-1:0] avs_address_in,
   input  wire logic              avs_read_in,
   input  wire logic              avs_write_in,
   input  wire logic [BUS_W-1:0]  avs_writedata_in,
   input  wire logic [3:0]        avs_byteenable_in,
   output logic [BUS_W-1:0]       avs_readdata_out,
   output logic [1:0]             avs_response_out,
   output logic                   avs_waitrequest_out,
   // Power-on strap levels for the output-only register
   input  wire logic [STRAP_W-1:0] strap_in,
   // Bidirectional lines
   input  wire logic              io_line_a_in,
   output logic                   io_line_a_out,
   output logic                   io_line_a_oe_out,
   input  wire logic              io_line_b_in,
   output logic                   io_line_b_out,
   output logic                   io_line_b_oe_out,
   input  wire logic              io_line_e_in,
   output logic                   io_line_e_out,
   output logic                   io_line_e_oe_out,
   input  wire logic              io_line_f_in,
   output logic                   io_line_f_out,
   output logic                   io_line_f_oe_out,
   input  wire logic              io_line_g_in,
   output logic                   io_line_g_out,
   output logic                   io_line_g_oe_out,
   // Alternate functions sharing the same pins
   input  wire logic              alt_line_a_out_in,
   input  wire logic              alt_line_a_oe_in,
   input  wire logic              alt_line_b_out_in,
   input  wire logic              alt_line_b_oe_in,
   input  wire logic              alt_line_e_out_in,
   input  wire logic              alt_line_e_oe_in,
   input  wire logic              alt_line_f_out_in,
   input  wire logic              alt_line_f_oe_in,
   input  wire logic              alt_line_g_out_in,
   input  wire logic              alt_line_g_oe_in,
   // Output-only lines
   output logic                   out_line_c_out,
   output logic                   out_line_c_oe_out,
   output logic                   out_line_d_out,
   output logic                   out_line_d_oe_out
);

   // Elaboration-time refusal of an address too narrow for the map
   if (ADDR_W < IDX_W + ADDR_LSB) begin : g_addr_check
      $error("ADDR_W too small for the register map");
   end

   bus_state_t         state_r;
   logic               waitrequest_r;
   logic [DATA_W-1:0]  readdata_r;
   logic [1:0]         response_r;

   logic [DATA_W-1:0]  func_select_r;
   logic [DATA_W-1:0]  direction_r;
   logic [DATA_W-1:0]  out_only_r;
   logic [DATA_W-1:0]  line_data_r;
   logic [DATA_W-1:0]  drive_type_r;

   logic [STRAP_W-1:0] strap_sync1_r;
   logic [STRAP_W-1:0] strap_sync2_r;

   logic               out_c_r;
   logic               out_c_oe_r;
   logic               out_d_r;
   logic               out_d_oe_r;

   logic [IDX_W-1:0]   reg_idx;
   logic               addr_hi_zero;
   logic               commit_wr;
   logic [DATA_W-1:0]  wr_byte;
   logic [DATA_W-1:0]  pin_level;
   logic [DATA_W-1:0]  readdata_nxt;
   logic [1:0]         response_nxt;

   logic               level_a;
   logic               level_b;
   logic               level_e;
   logic               level_f;
   logic               level_g;

   assign reg_idx      = avs_address_in[ADDR_LSB +: IDX_W];
   assign addr_hi_zero = (avs_address_in >> (IDX_W + ADDR_LSB)) == '0;
   assign wr_byte      = avs_writedata_in[DATA_W-1:0];
   // A write lands at the edge where the master sees waitrequest low
   assign commit_wr    = (state_r == BUS_ACK) && avs_write_in && avs_byteenable_in[0] && addr_hi_zero;

   // Bus handshake: one wait cycle, then a one-cycle acknowledge
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         state_r       <= BUS_IDLE;
         waitrequest_r <= 1'b1;
      end else begin
         case (state_r)
            BUS_IDLE: begin
               if (avs_read_in || avs_write_in) begin
                  state_r       <= BUS_ACK;
                  waitrequest_r <= 1'b0;
               end
            end
            BUS_ACK: begin
               state_r       <= BUS_IDLE;
               waitrequest_r <= 1'b1;
            end
            default: begin
               state_r       <= BUS_IDLE;
               waitrequest_r <= 1'b1;
            end
         endcase
      end
   end

   // Pin levels placed at their data-register positions
   always_comb begin
      pin_level             = '0;
      pin_level[BIT_LINE_B] = level_b;
      pin_level[BIT_LINE_A] = level_a;
      pin_level[BIT_LINE_G] = level_g;
      pin_level[BIT_LINE_F] = level_f;
      pin_level[BIT_LINE_E] = level_e;
   end

   // Read decode
   always_comb begin
      readdata_nxt = '0;
      response_nxt = RESP_OKAY;
      if (!addr_hi_zero) begin
         response_nxt = RESP_DECODEERR;
      end else begin
         case (reg_idx)
            IDX_FUNC_SELECT:   readdata_nxt = func_select_r;
            IDX_DIRECTION:     readdata_nxt = direction_r;
            IDX_OUT_ONLY_DATA: readdata_nxt = out_only_r;
            IDX_LINE_DATA:     readdata_nxt = pin_level;
            IDX_VENDOR_LO:     readdata_nxt = VENDOR_CODE[7:0];
            IDX_VENDOR_HI:     readdata_nxt = VENDOR_CODE[15:8];
            IDX_CHIP_CODE:     readdata_nxt = PART_CODE;
            IDX_RESERVED_A:    readdata_nxt = '0;
            IDX_RESERVED_B:    readdata_nxt = '0;
            IDX_DRIVE_TYPE:    readdata_nxt = drive_type_r;
            default:           response_nxt = RESP_DECODEERR;
         endcase
      end
   end

   // Read data and response are caught with the request and stand through the acknowledge
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         readdata_r <= RST_READDATA;
         response_r <= RESP_OKAY;
      end else if (state_r == BUS_IDLE && (avs_read_in || avs_write_in)) begin
         readdata_r <= avs_read_in ? readdata_nxt : RST_READDATA;
         response_r <= response_nxt;
      end
   end

   assign avs_readdata_out    = {READ_PAD, readdata_r};
   assign avs_response_out    = response_r;
   assign avs_waitrequest_out = waitrequest_r;

   // Function select
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         func_select_r <= RST_FUNC_SELECT;
      end else if (commit_wr && reg_idx == IDX_FUNC_SELECT) begin
         func_select_r <= wr_byte & MASK_FUNC_SEL;
      end
   end

   // Direction
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         direction_r <= RST_DIRECTION;
      end else if (commit_wr && reg_idx == IDX_DIRECTION) begin
         direction_r <= wr_byte & MASK_LINES;
      end
   end

   // Line output values
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         line_data_r <= RST_LINE_DATA;
      end else if (commit_wr && reg_idx == IDX_LINE_DATA) begin
         line_data_r <= wr_byte & MASK_LINES;
      end
   end

   // Drive type
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         drive_type_r <= RST_DRIVE_TYPE;
      end else if (commit_wr && reg_idx == IDX_DRIVE_TYPE) begin
         drive_type_r <= wr_byte & MASK_LINES;
      end
   end

   // Strap synchroniser runs through reset so the captured level is valid at release
   always_ff @(posedge sys_clk_in) begin
      strap_sync1_r <= strap_in;
      strap_sync2_r <= strap_sync1_r;
   end

   // Output-only data; identification and reserved slots have no storage to write
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         out_only_r <= {RST_OUT_TOP, strap_sync2_r};
      end else if (commit_wr && reg_idx == IDX_OUT_ONLY_DATA) begin
         out_only_r <= wr_byte & MASK_OUT_ONLY;
      end
   end

   // Output-only lines, gated together by one enable
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         out_c_r    <= 1'b0;
         out_c_oe_r <= 1'b0;
         out_d_r    <= 1'b0;
         out_d_oe_r <= 1'b0;
      end else begin
         out_c_r    <= func_select_r[FSEL_OUT_CD] & out_only_r[BIT_OUT_C];
         out_c_oe_r <= func_select_r[FSEL_OUT_CD];
         out_d_r    <= func_select_r[FSEL_OUT_CD] & out_only_r[BIT_OUT_D];
         out_d_oe_r <= func_select_r[FSEL_OUT_CD];
      end
   end

   assign out_line_c_out    = out_c_r;
   assign out_line_c_oe_out = out_c_oe_r;
   assign out_line_d_out    = out_d_r;
   assign out_line_d_oe_out = out_d_oe_r;

   io_line_ctrl u_line_b (
      .sys_clk_in   (sys_clk_in),
      .reset_in     (reset_in),
      .gpio_sel_in  (func_select_r[FSEL_LINE_B]),
      .dir_out_in   (direction_r[BIT_LINE_B]),
      .push_pull_in (drive_type_r[BIT_LINE_B]),
      .value_in     (line_data_r[BIT_LINE_B]),
      .alt_out_in   (alt_line_b_out_in),
      .alt_oe_in    (alt_line_b_oe_in),
      .pin_in       (io_line_b_in),
      .pin_out      (io_line_b_out),
      .pin_oe_out   (io_line_b_oe_out),
      .level_out    (level_b)
   );

   io_line_ctrl u_line_a (
      .sys_clk_in   (sys_clk_in),
      .reset_in     (reset_in),
      .gpio_sel_in  (func_select_r[FSEL_LINE_A]),
      .dir_out_in   (direction_r[BIT_LINE_A]),
      .push_pull_in (drive_type_r[BIT_LINE_A]),
      .value_in     (line_data_r[BIT_LINE_A]),
      .alt_out_in   (alt_line_a_out_in),
      .alt_oe_in    (alt_line_a_oe_in),
      .pin_in       (io_line_a_in),
      .pin_out      (io_line_a_out),
      .pin_oe_out   (io_line_a_oe_out),
      .level_out    (level_a)
   );

   io_line_ctrl u_line_g (
      .sys_clk_in   (sys_clk_in),
      .reset_in     (reset_in),
      .gpio_sel_in  (func_select_r[FSEL_LINE_G]),
      .dir_out_in   (direction_r[BIT_LINE_G]),
      .push_pull_in (drive_type_r[BIT_LINE_G]),
      .value_in     (line_data_r[BIT_LINE_G]),
      .alt_out_in   (alt_line_g_out_in),
      .alt_oe_in    (alt_line_g_oe_in),
      .pin_in       (io_line_g_in),
      .pin_out      (io_line_g_out),
      .pin_oe_out   (io_line_g_oe_out),
      .level_out    (level_g)
   );

   io_line_ctrl u_line_f (
      .sys_clk_in   (sys_clk_in),
      .reset_in     (reset_in),
      .gpio_sel_in  (func_select_r[FSEL_LINE_F]),
      .dir_out_in   (direction_r[BIT_LINE_F]),
      .push_pull_in (drive_type_r[BIT_LINE_F]),
      .value_in     (line_data_r[BIT_LINE_F]),
      .alt_out_in   (alt_line_f_out_in),
      .alt_oe_in    (alt_line_f_oe_in),
      .pin_in       (io_line_f_in),
      .pin_out      (io_line_f_out),
      .pin_oe_out   (io_line_f_oe_out),
      .level_out    (level_f)
   );

   io_line_ctrl u_line_e (
      .sys_clk_in   (sys_clk_in),
      .reset_in     (reset_in),
      .gpio_sel_in  (func_select_r[FSEL_LINE_E]),
      .dir_out_in   (direction_r[BIT_LINE_E]),
      .push_pull_in (drive_type_r[BIT_LINE_E]),
      .value_in     (line_data_r[BIT_LINE_E]),
      .alt_out_in   (alt_line_e_out_in),
      .alt_oe_in    (alt_line_e_oe_in),
      .pin_in       (io_line_e_in),
      .pin_out      (io_line_e_out),
      .pin_oe_out   (io_line_e_oe_out),
      .level_out    (level_e)
   );

endmodule : monitor_gpio_and_id_regs

//--- sim/gpio_regs_checker.sv
// Concurrent checks on the bus handshake, id bytes and output-only lines
`timescale 1ns/10ps
module gpio_regs_checker
   import gpio_regs_pkg::*;
#(
   parameter int          ADDR_W      = 10,
   parameter logic [15:0] VENDOR_CODE = 16'h1234,
   parameter logic [7:0]  PART_CODE   = 8'h42
) (
   input wire logic              sys_clk_in,
   input wire logic              reset_in,
   input wire logic [ADDR_W-1:0] avs_address_in,
   input wire logic              avs_read_in,
   input wire logic              avs_write_in,
   input wire logic [BUS_W-1:0]  avs_readdata_out,
   input wire logic [1:0]        avs_response_out,
   input wire logic              avs_waitrequest_out,
   input wire logic              out_line_c_out,
   input wire logic              out_line_c_oe_out,
   input wire logic              out_line_d_out,
   input wire logic              out_line_d_oe_out
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (reset_in);
   logic [7:0] idx;
   logic       mapped;
   assign idx    = avs_address_in[9:2];
   assign mapped = ((avs_address_in >> 10) == 0) &&
                   ((idx == IDX_FUNC_SELECT) || (idx >= IDX_DIRECTION && idx <= IDX_DRIVE_TYPE));
   sequence taken_s;
      (avs_read_in || avs_write_in) && avs_waitrequest_out;
   endsequence
   sequence ack_s;
      !avs_waitrequest_out ##1 avs_waitrequest_out;
   endsequence
   sequence rd_s(logic [7:0] i);
      avs_read_in && avs_waitrequest_out && mapped && idx == i;
   endsequence
   bus_answer_a: assert property (taken_s |=> ack_s) else $error("no single-cycle answer");
   ack_cause_a: assert property ($fell(avs_waitrequest_out) |-> $past(avs_read_in || avs_write_in))
      else $error("answer without request");
   read_hold_a: assert property (!avs_waitrequest_out |=> $stable(avs_readdata_out) && $stable(avs_response_out))
      else $error("read data moved after answer");
   decode_err_a: assert property (avs_read_in && avs_waitrequest_out && !mapped |=>
      avs_response_out == RESP_DECODEERR && avs_readdata_out == '0) else $error("unmapped read answered");
   mapped_okay_a: assert property (taken_s and mapped |=> avs_response_out == RESP_OKAY)
      else $error("mapped access refused");
   vendor_low_a: assert property (rd_s(IDX_VENDOR_LO) |=> avs_readdata_out == {READ_PAD, VENDOR_CODE[7:0]})
      else $error("vendor low byte wrong");
   vendor_high_a: assert property (rd_s(IDX_VENDOR_HI) |=> avs_readdata_out == {READ_PAD, VENDOR_CODE[15:8]})
      else $error("vendor high byte wrong");
   chip_code_a: assert property (rd_s(IDX_CHIP_CODE) |=> avs_readdata_out == {READ_PAD, PART_CODE})
      else $error("chip code wrong");
   out_pair_a: assert property (out_line_c_oe_out == out_line_d_oe_out)
      else $error("output-only enables differ");
   out_off_a: assert property (!out_line_c_oe_out |-> !out_line_c_out && !out_line_d_out)
      else $error("disabled output-only line driven");
endmodule : gpio_regs_checker

bind monitor_gpio_and_id_regs gpio_regs_checker #(.ADDR_W(ADDR_W), .VENDOR_CODE(VENDOR_CODE),
   .PART_CODE(PART_CODE)) chk (.sys_clk_in, .reset_in, .avs_address_in, .avs_read_in, .avs_write_in,
   .avs_readdata_out, .avs_response_out, .avs_waitrequest_out, .out_line_c_out, .out_line_c_oe_out,
   .out_line_d_out, .out_line_d_oe_out);

//--- sim/tb_monitor_gpio_and_id_regs.sv
// Self-checking bench for the monitor pin and identification registers
`timescale 1ns/10ps
module tb_monitor_gpio_and_id_regs;
   import gpio_regs_pkg::*;
   localparam logic [15:0] VCODE = 16'hbeef; // Value is arbitrary
   localparam logic [7:0]  PCODE = 8'h5a;    // Value is arbitrary
   localparam logic [23:0] TBL [7] = '{24'hffffff, 24'h737300, 24'h730073, 24'h730c00, 24'h524231,
                                       24'h21f373, 24'h007373};
   logic        sys_clk_in = 1'b0;
   logic        reset_in = 1'b1;
   logic [9:0]  avs_address_in = '0;
   logic        avs_read_in = 1'b0;
   logic        avs_write_in = 1'b0;
   logic [31:0] avs_writedata_in = '0;
   logic [3:0]  avs_byteenable_in = '0;
   logic [4:0]  strap_in = 5'h15;
   logic [7:0]  ext = '0;
   logic [7:0]  alt_out = '0;
   logic [7:0]  alt_oe = '0;
   logic [31:0] rdata;
   logic [1:0]  rresp;
   int          err_count = 0;
   int          samples_checked = 0;
   int          cyc = 0;
   wire logic [31:0] avs_readdata_out;
   wire logic [1:0]  avs_response_out;
   wire logic        avs_waitrequest_out, a_o, a_e, b_o, b_e, e_o, e_e, f_o, f_e, g_o, g_e, c_o, c_e, d_o, d_e;
   wire logic [7:0]  pout = {1'b0, b_o, a_o, g_o, 2'b00, f_o, e_o};
   wire logic [7:0]  poe  = {1'b0, b_e, a_e, g_e, 2'b00, f_e, e_e};
   wire logic [7:0]  pin  = (poe & pout) | (~poe & ext);

   monitor_gpio_and_id_regs #(.ADDR_W(10), .VENDOR_CODE(VCODE), .PART_CODE(PCODE)) DUT (
      .sys_clk_in, .reset_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
      .avs_byteenable_in, .avs_readdata_out, .avs_response_out, .avs_waitrequest_out, .strap_in,
      .io_line_a_in(pin[5]), .io_line_a_out(a_o), .io_line_a_oe_out(a_e),
      .io_line_b_in(pin[6]), .io_line_b_out(b_o), .io_line_b_oe_out(b_e),
      .io_line_e_in(pin[0]), .io_line_e_out(e_o), .io_line_e_oe_out(e_e),
      .io_line_f_in(pin[1]), .io_line_f_out(f_o), .io_line_f_oe_out(f_e),
      .io_line_g_in(pin[4]), .io_line_g_out(g_o), .io_line_g_oe_out(g_e),
      .alt_line_a_out_in(alt_out[5]), .alt_line_a_oe_in(alt_oe[5]),
      .alt_line_b_out_in(alt_out[6]), .alt_line_b_oe_in(alt_oe[6]),
      .alt_line_e_out_in(alt_out[0]), .alt_line_e_oe_in(alt_oe[0]),
      .alt_line_f_out_in(alt_out[1]), .alt_line_f_oe_in(alt_oe[1]),
      .alt_line_g_out_in(alt_out[4]), .alt_line_g_oe_in(alt_oe[4]),
      .out_line_c_out(c_o), .out_line_c_oe_out(c_e), .out_line_d_out(d_o), .out_line_d_oe_out(d_e));

   always #5 sys_clk_in = ~sys_clk_in;

   task automatic tally_and_finish;
      if (err_count == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : tally_and_finish

   // Hangs end the run with a counted mismatch
   always @(posedge sys_clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         err_count++;
         tally_and_finish;
      end
   end

   task automatic check(input logic [39:0] got, input logic [39:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // One Avalon cycle; waitrequest, read data and response are taken at the same rising edge
   task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d, input logic [3:0] be);
      @(posedge sys_clk_in);
      avs_address_in <= {i, 2'b00};
      avs_writedata_in <= {24'ha5a5a5, d};
      avs_byteenable_in <= be;
      avs_read_in <= !w;
      avs_write_in <= w;
      do begin
         @(posedge sys_clk_in);
      end while (avs_waitrequest_out !== 1'b0);
      rdata = avs_readdata_out;
      rresp = avs_response_out;
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
   endtask : bus

   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      bus(1'b1, i, d, 4'hf);
   endtask : wr

   task automatic rd(input logic [7:0] i, input logic [7:0] d, input logic [1:0] r);
      bus(1'b0, i, 8'h00, 4'h0);
      check({rresp, rdata}, {r, READ_PAD, d});
   endtask : rd

   task automatic settle;
      repeat (2) @(posedge sys_clk_in);
      @(negedge sys_clk_in);
   endtask : settle

   task automatic t_reset(input logic [4:0] s);
      @(posedge sys_clk_in);
      reset_in <= 1'b1;
      strap_in <= s;
      ext <= 8'h00;
      repeat (12) @(posedge sys_clk_in);
      reset_in <= 1'b0;
      @(negedge sys_clk_in);
      check({d_e, d_o, c_e, c_o, poe}, '0);
      rd(IDX_FUNC_SELECT, 8'h00, RESP_OKAY);
      rd(IDX_DIRECTION, 8'h00, RESP_OKAY);
      rd(IDX_LINE_DATA, 8'h00, RESP_OKAY);
      rd(IDX_DRIVE_TYPE, 8'h00, RESP_OKAY);
      strap_in <= ~s;
      rd(IDX_OUT_ONLY_DATA, {3'h0, s}, RESP_OKAY);
   endtask : t_reset

   task automatic t_ids;
      for (int i = 0; i < 5; i++) wr(IDX_VENDOR_LO + i[7:0], 8'hc3);
      rd(IDX_VENDOR_LO, VCODE[7:0], RESP_OKAY);
      rd(IDX_VENDOR_HI, VCODE[15:8], RESP_OKAY);
      rd(IDX_CHIP_CODE, PCODE, RESP_OKAY);
      rd(IDX_RESERVED_A, 8'h00, RESP_OKAY);
      rd(IDX_RESERVED_B, 8'h00, RESP_OKAY);
      rd(8'h48, 8'h00, RESP_DECODEERR);
      rd(8'hff, 8'h00, RESP_DECODEERR);
   endtask : t_ids

   task automatic t_out_lines;
      logic [7:0] v;
      wr(IDX_FUNC_SELECT, 8'h01);
      for (int i = 0; i < 4; i++) begin
         v = {1'b0, i[1:0], 5'h00};
         wr(IDX_OUT_ONLY_DATA, v);
         settle;
         check({d_e, d_o, c_e, c_o}, {1'b1, v[6], 1'b1, v[5]});
      end
      wr(IDX_OUT_ONLY_DATA, 8'hff);
      bus(1'b1, IDX_OUT_ONLY_DATA, 8'h00, 4'he);
      rd(IDX_OUT_ONLY_DATA, 8'h7f, RESP_OKAY);
      wr(IDX_FUNC_SELECT, 8'h00);
      settle;
      check({d_e, d_o, c_e, c_o}, 4'h0);
   endtask : t_out_lines

   task automatic t_lines;
      logic [7:0] dr, dt, da, eo, ee, e;
      wr(IDX_FUNC_SELECT, 8'he7);
      foreach (TBL[n]) begin
         {dr, dt, da} = TBL[n];
         wr(IDX_DIRECTION, dr);
         wr(IDX_DRIVE_TYPE, dt);
         wr(IDX_LINE_DATA, da);
         ee = dr & (dt | ~da) & MASK_LINES;
         eo = dr & dt & da & MASK_LINES;
         settle;
         check({pout, poe}, {eo, ee});
         rd(IDX_DIRECTION, dr & MASK_LINES, RESP_OKAY);
         rd(IDX_DRIVE_TYPE, dt & MASK_LINES, RESP_OKAY);
         for (int x = 0; x < 2; x++) begin
            e = x[0] ? 8'hff : 8'h00;
            ext <= e;
            repeat (4) @(posedge sys_clk_in);
            rd(IDX_LINE_DATA, ((ee & eo) | (~ee & e)) & MASK_LINES, RESP_OKAY);
         end
      end
   endtask : t_lines

   task automatic t_alt;
      int fb [5] = '{1, 2, 5, 6, 7};
      int lb [5] = '{0, 1, 4, 5, 6};
      logic [7:0] m;
      alt_out <= 8'h21;
      alt_oe <= 8'h52;
      wr(IDX_DIRECTION, 8'h00);
      wr(IDX_FUNC_SELECT, 8'h00);
      settle;
      check({pout, poe}, {8'h21, 8'h52});
      wr(IDX_DIRECTION, 8'h73);
      wr(IDX_DRIVE_TYPE, 8'h73);
      wr(IDX_LINE_DATA, 8'h73);
      for (int k = 0; k < 5; k++) begin
         m = 8'h01 << lb[k];
         wr(IDX_FUNC_SELECT, 8'h01 << fb[k]);
         settle;
         check({pout, poe}, {(8'h21 & ~m) | m, (8'h52 & ~m) | m});
      end
   endtask : t_alt

   initial begin
      t_reset(5'h15);
      t_ids;
      t_out_lines;
      t_lines;
      t_alt;
      t_reset(5'h0a);
      tally_and_finish;
   end
endmodule : tb_monitor_gpio_and_id_regs
